// >>> hdl/iblh_pkg.sv
// Package for the instrument bus listener handshake block
package iblh_pkg;

   // ****************************************
   // Widths and constants
   // ****************************************
   localparam int IBLH_DATA_W = 8;          // Byte width on the data lines
   localparam int IBLH_ADDR_W = 7;          // Listen address width
   localparam int IBLH_FIFO_DEPTH = 8;      // Receive buffer depth
   localparam logic [6:0] IBLH_ADDR_DEF = 7'h05; // Default listen address
   localparam logic [6:0] IBLH_UNL_CODE = 7'h3F; // Unlisten command code
   localparam logic [1:0] IBLH_GRP_LISTEN = 2'h1; // Listen address group
   localparam int IBLH_GRP_LSB = 5;         // Group field position
   localparam int IBLH_SYNC_STAGES = 2;     // Synchroniser depth

   // ****************************************
   // Types
   // ****************************************
   // Bus inputs, active high sense (true = asserted)
   typedef struct packed {
      logic [7:0] data;
      logic dav;
      logic atn;
      logic ifc;
   } iblh_bus_in_t;

   // Received byte with its parity bit split out
   typedef struct packed {
      logic par;
      logic [6:0] ch;
   } iblh_byte_t;

   // Handshake states, one-hot
   typedef enum logic [4:0] {
      IBLH_IDLE = 5'b00001,
      IBLH_READY = 5'b00010,
      IBLH_TAKE = 5'b00100,
      IBLH_ACCEPT = 5'b01000,
      IBLH_HOLD = 5'b10000
   } iblh_state_t;

endpackage : iblh_pkg

// >>> hdl/iblh_fifo.sv
// Parameterised valid/ready FIFO for received bytes
`timescale 1ns/1ps
module iblh_fifo
   import iblh_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // Storage array
   logic [AW-1:0] wr_ptr_r;        // Write pointer
   logic [AW-1:0] rd_ptr_r;        // Read pointer
   logic [AW:0] cnt_r;             // Fill count
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_r];

   // Storage write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : iblh_fifo

// >>> hdl/iblh_listener.sv
// Listener side of the three-wire interlocked byte handshake
//
// Overview of operation
// [R1] Release not-ready line when ready for byte
// [R2] Not-ready line is wired-AND, open drain
// [R3] Talker asserts valid only after not-ready high
// [R4] On valid: hold not-ready, capture, release not-accepted
// [R5] Not-accepted line is wired-AND, open drain
// [R6] Talker drops valid only after not-accepted high
// [R7] Valid released: pull not-accepted, then ready again
// [R8] Eight parallel data lines, one byte per cycle
// [R9] Eighth bit may carry parity, tolerated
// [R10] No fixed rate; every step waits on partner
// [R11] Listen only after own address in command mode
// [R12] Bytes are data only while attention false
// [R13] Interface clear drops addressed state at once
// [R14] Two-stage synchroniser on every bus input
// [R15] Release both lines when unaddressed or reset; code still drives them while attention is true
`timescale 1ns/1ps
module iblh_listener
   import iblh_pkg::*;
#(
   parameter int FIFO_DEPTH = IBLH_FIFO_DEPTH
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [IBLH_ADDR_W-1:0] MY_ADDR,
   input wire logic [IBLH_DATA_W-1:0] DIO_B,
   input wire logic DAV_B,
   input wire logic ATN_B,
   input wire logic IFC_B,
   input wire logic NRFD_IN,
   input wire logic NDAC_IN,
   output logic NRFD_OUT,
   output logic NRFD_OE,
   output logic NDAC_OUT,
   output logic NDAC_OE,
   output logic LISTEN,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [IBLH_DATA_W-1:0] RX_DATA
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   iblh_bus_in_t raw;              // Inverted to true-high sense
   iblh_bus_in_t s1_r;             // First stage, read only by second
   iblh_bus_in_t s2_r;             // Second stage, used by logic

   assign raw = '{data: ~DIO_B, dav: ~DAV_B, atn: ~ATN_B, ifc: ~IFC_B};

   // [R14] two-stage synchroniser
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end

   // ****************************************
   // Handshake state and addressing
   // ****************************************
   iblh_state_t state_r;           // Handshake state
   iblh_byte_t byte_r;             // Captured byte
   logic cmd_r;                    // Byte taken under attention
   logic listen_r;                 // Addressed as listener
   logic take_r;                   // One-cycle capture marker
   logic fifo_in_ready;            // Buffer has room
   logic fifo_out_valid;
   logic [IBLH_DATA_W-1:0] fifo_out_data;
   logic active;                   // Takes part in handshake

   // Listen during command mode too, so addressing works
   assign active = listen_r || s2_r.atn;

   // Handshake sequencing
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_r <= IBLH_IDLE;
         byte_r <= '0;
         cmd_r <= 1'b0;
         take_r <= 1'b0;
      end
      else
      begin
         take_r <= 1'b0;
         case (state_r)
            IBLH_IDLE:
            begin
               // [R15] stay off the lines while inactive
               if (active && !s2_r.ifc)
               begin
                  state_r <= IBLH_READY;
               end
            end
            // [R10] waits on talker, no fixed rate
            IBLH_READY:
            begin
               // [R4] valid seen, hold off and capture
               if (s2_r.dav)
               begin
                  state_r <= IBLH_TAKE;
                  byte_r <= iblh_byte_t'(s2_r.data);
                  cmd_r <= s2_r.atn;
               end
               else if (!active || s2_r.ifc)
               begin
                  state_r <= IBLH_IDLE;
               end
            end
            IBLH_TAKE:
            begin
               // [R12] only data bytes need buffer room
               if (cmd_r || fifo_in_ready)
               begin
                  take_r <= 1'b1;
                  state_r <= IBLH_ACCEPT;
               end
            end
            IBLH_ACCEPT:
            begin
               // [R7] valid gone, pull accepted low again
               if (!s2_r.dav)
               begin
                  state_r <= IBLH_HOLD;
               end
            end
            IBLH_HOLD:
            begin
               // [R7] restart cycle with readiness
               state_r <= IBLH_IDLE;
            end
            default:
            begin
               state_r <= IBLH_IDLE;
            end
         endcase
         // [R13] interface clear abandons transfer
         if (s2_r.ifc)
         begin
            state_r <= IBLH_IDLE;
            take_r <= 1'b0;
         end
      end
   end

   // Listener addressing
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         listen_r <= 1'b0;
      end
      // [R13] interface clear unaddresses
      else if (s2_r.ifc)
      begin
         listen_r <= 1'b0;
      end
      // [R11] own listen address in command mode
      else if (take_r && cmd_r)
      begin
         if (byte_r.ch == IBLH_UNL_CODE)
         begin
            listen_r <= 1'b0;
         end
         else if (byte_r.ch[IBLH_ADDR_W-1:IBLH_GRP_LSB] == IBLH_GRP_LISTEN &&
                  byte_r.ch[IBLH_GRP_LSB-1:0] == MY_ADDR[IBLH_GRP_LSB-1:0])
         begin
            listen_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Open-drain line drive
   // ****************************************
   // [R1] [R2] while active and not clearing, not-ready released only in ready state
   // [R5] while active and not clearing, not-accepted released only after capture
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         NRFD_OE <= 1'b0;
         NDAC_OE <= 1'b0;
         LISTEN <= 1'b0;
      end
      else
      begin
         NRFD_OE <= active && !s2_r.ifc && (state_r != IBLH_READY);
         NDAC_OE <= active && !s2_r.ifc && (state_r != IBLH_ACCEPT);
         LISTEN <= listen_r;
      end
   end

   // Lines are only ever pulled low
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         NRFD_OUT <= 1'b0;
         NDAC_OUT <= 1'b0;
      end
      else
      begin
         NRFD_OUT <= 1'b0;
         NDAC_OUT <= 1'b0;
      end
   end

   // ****************************************
   // Receive buffer
   // ****************************************
   // [R8] [R9] full byte kept, parity bit untouched
   iblh_fifo #(
      .WIDTH(IBLH_DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst_b(RST_B),
      .in_valid(take_r && !cmd_r),
      .in_ready(fifo_in_ready),
      .in_data(byte_r),
      .out_valid(fifo_out_valid),
      .out_ready(RX_READY && !RX_VALID),
      .out_data(fifo_out_data)
   );

   // Registered output stage
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         RX_VALID <= 1'b0;
         RX_DATA <= '0;
      end
      else if (fifo_out_valid && RX_READY && !RX_VALID)
      begin
         RX_VALID <= 1'b1;
         RX_DATA <= fifo_out_data;
      end
      else
      begin
         RX_VALID <= 1'b0;
      end
   end

endmodule : iblh_listener

// >>> tb/iblh_monitor.sv
// Port checker for the listener handshake
`timescale 1ns/1ps
module iblh_monitor
   import iblh_pkg::*;
(
   input logic CLK,
   input logic RST_B,
   input logic DAV_B,
   input logic ATN_B,
   input logic IFC_B,
   input logic NRFD_OUT,
   input logic NRFD_OE,
   input logic NDAC_OUT,
   input logic NDAC_OE,
   input logic LISTEN,
   input logic RX_VALID,
   input logic RX_READY
);
   property p_od;
      @(posedge CLK) disable iff (!RST_B)
      !NRFD_OUT && !NDAC_OUT;
   endproperty
   a_od: assert property (p_od)
      else $error("shared line driven high");
   // valid seen synchronised
   // Pulled-before guard skips the rise when becoming active
   property p_sync;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      $rose(NRFD_OE) && $past(NDAC_OE) |-> !$past(DAV_B) && !$past(DAV_B, 4);
   endproperty
   a_sync: assert property (p_sync)
      else $error("valid taken unsynced");
   property p_take;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      $fell(NDAC_OE) && LISTEN |-> NRFD_OE && !DAV_B;
   endproperty
   a_take: assert property (p_take)
      else $error("accept out of order");
   property p_hold;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      NRFD_OE && !DAV_B |=> NRFD_OE;
   endproperty
   a_hold: assert property (p_hold)
      else $error("not-ready dropped early");
   property p_drop;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      $rose(DAV_B) && NRFD_OE |-> ##[1:4] NDAC_OE;
   endproperty
   a_drop: assert property (p_drop)
      else $error("accept line not pulled");
   property p_rdy;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      $rose(NDAC_OE) && NRFD_OE |-> ##[1:3] !NRFD_OE;
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("not ready again");
   property p_addr;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      $rose(LISTEN) |-> !$past(ATN_B, 2);
   endproperty
   a_addr: assert property (p_addr)
      else $error("listen outside command mode");
   // clear drops all
   // Two sync stages plus registered outputs need five samples
   property p_ifc;
      @(posedge CLK) disable iff (!RST_B)
      !IFC_B [*5] |-> !LISTEN && !NRFD_OE && !NDAC_OE;
   endproperty
   a_ifc: assert property (p_ifc)
      else $error("clear ignored");
   property p_rel;
      @(posedge CLK) disable iff (!RST_B || !IFC_B)
      (!LISTEN && ATN_B) [*6] |-> !NRFD_OE && !NDAC_OE;
   endproperty
   a_rel: assert property (p_rel)
      else $error("lines held unaddressed");
   property p_rxp;
      @(posedge CLK) disable iff (!RST_B)
      RX_VALID |-> $past(RX_READY) ##1 !RX_VALID;
   endproperty
   a_rxp: assert property (p_rxp)
      else $error("receive pulse wrong");
endmodule : iblh_monitor
bind iblh_listener iblh_monitor u_iblh_monitor (.CLK(CLK), .RST_B(RST_B), .DAV_B(DAV_B),
   .ATN_B(ATN_B), .IFC_B(IFC_B), .NRFD_OUT(NRFD_OUT), .NRFD_OE(NRFD_OE), .NDAC_OUT(NDAC_OUT),
   .NDAC_OE(NDAC_OE), .LISTEN(LISTEN), .RX_VALID(RX_VALID), .RX_READY(RX_READY));

// >>> tb/iblh_talker.sv
// Behavioural bus talker
`timescale 1ns/1ps
module iblh_talker
   import iblh_pkg::*;
(
   input logic clk,
   input logic nrfd_w,
   input logic ndac_w,
   output logic [7:0] dio_b,
   output logic dav_b
);
   // Idle bus
   initial
   begin
      dio_b = 8'hFF;
      dav_b = 1'b1;
   end
   // One interlocked transfer
   // A stuck handshake is left to the bench watchdog
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      while (nrfd_w !== 1'b1)
      begin
         @(posedge clk);
      end
      repeat ($urandom_range(0, 3)) @(posedge clk);
      #1 dio_b = ~b;
      dav_b = 1'b0;
      // wait for accept, judged at edges only
      @(posedge clk);
      while (ndac_w !== 1'b1)
      begin
         @(posedge clk);
      end
      repeat ($urandom_range(0, 3)) @(posedge clk);
      // Valid released, data lines float back high
      #1 dav_b = 1'b1;
      dio_b = 8'hFF;
   endtask : send
endmodule : iblh_talker

// >>> tb/tb_top.sv
// Self-checking bench for the listener handshake
`timescale 1ns/1ps
module tb_top
   import iblh_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic atn_b = 1'b1;
   logic ifc_b = 1'b1;
   logic rx_ready = 1'b0;
   logic rd_en = 1'b0; // Consumer enable
   logic [6:0] my_addr = IBLH_ADDR_DEF;
   logic [7:0] dio_b, rx_data;
   logic dav_b, nrfd_oe, ndac_oe, nrfd_out, ndac_out, listen, rx_valid;
   logic [7:0] exp_q[$]; // Expected bytes
   int num_errors = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   iblh_listener #(.FIFO_DEPTH(IBLH_FIFO_DEPTH)) u_iblh_listener (.CLK(clk), .RST_B(rst_b),
      .MY_ADDR(my_addr), .DIO_B(dio_b), .DAV_B(dav_b), .ATN_B(atn_b), .IFC_B(ifc_b),
      .NRFD_IN(~nrfd_oe), .NDAC_IN(~ndac_oe), .NRFD_OUT(nrfd_out), .NRFD_OE(nrfd_oe),
      .NDAC_OUT(ndac_out), .NDAC_OE(ndac_oe), .LISTEN(listen), .RX_VALID(rx_valid),
      .RX_READY(rx_ready), .RX_DATA(rx_data));
   iblh_talker u_iblh_talker (.clk(clk), .nrfd_w(~nrfd_oe), .ndac_w(~ndac_oe), .dio_b(dio_b),
      .dav_b(dav_b));
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("compared=%0d errors=%0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // Send, noting bytes to be kept
   task automatic put(input logic [7:0] b, input logic keep);
      if (keep)
         exp_q.push_back(b);
      u_iblh_talker.send(b);
   endtask : put
   // Command byte under attention
   task automatic cmd(input logic [7:0] b);
      @(posedge clk) #1 atn_b = 1'b0;
      repeat (4) @(posedge clk);
      put(b, 1'b0);
      repeat (8) @(posedge clk);
      #1 atn_b = 1'b1;
      repeat (8) @(posedge clk);
   endtask : cmd
   // Random stalling consumer
   always @(posedge clk)
      rx_ready <= #1 rd_en & 1'($urandom_range(0, 1));
   // Received byte checker
   always @(posedge clk)
      if (rx_valid === 1'b1)
         chk(rx_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
   initial
   begin
      void'($urandom(32'h9FDCBD76));
      // Address 31 would alias the unlisten code
      my_addr = 7'($urandom_range(0, 30));
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      cmd({IBLH_GRP_LISTEN, my_addr[4:0]});
      chk({7'h00, listen}, 8'h01);
      $display("test 1 done");
      fork
         for (int i = 0; i < 12; i++)
            put(8'($urandom), 1'b1);
         begin
            repeat (400) @(posedge clk);
            #1 chk({7'h00, ndac_oe}, 8'h01);
            rd_en = 1'b1;
         end
      join
      for (int n = 0; n < 500 && exp_q.size() > 0; n++)
         @(posedge clk);
      chk(8'(exp_q.size()), 8'h00);
      $display("test 2 done");
      cmd(IBLH_UNL_CODE);
      chk({7'h00, listen}, 8'h00);
      // Another device's listen address is ignored
      cmd({IBLH_GRP_LISTEN, 5'(my_addr[4:0] + 5'h01)});
      chk({7'h00, listen}, 8'h00);
      put(8'hA5, 1'b0);
      repeat (20) @(posedge clk);
      $display("test 3 done");
      cmd({IBLH_GRP_LISTEN, my_addr[4:0]});
      @(posedge clk) #1 ifc_b = 1'b0;
      repeat (6) @(posedge clk);
      #1 chk({7'h00, listen}, 8'h00);
      ifc_b = 1'b1;
      put(8'h5A, 1'b0);
      repeat (20) @(posedge clk);
      $display("test 4 done");
      final_report();
   end
   // Watchdog
   initial
   begin
      #300000;
      num_errors++;
      final_report();
   end
endmodule : tb_top
